// *** core/wtiu_map.vh ***
// Purpose: constants for the waveform trigger input unit
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: included by core/wtiu_top.v
//
// Overview of operation
// R01 - the main trigger slope is level, rising, falling or either edge, and level mode acts on the level itself.
// R02 - the analog trigger sample is compared against a programmable threshold and that result is what the slope acts on.
// R03 - a readable main trigger flag shows whether a trigger was detected.
// R04 - a separate readable flag shows whether an auxiliary trigger was detected.
// R05 - software selects which digital input serves as the digital trigger source.
// R06 - a readable indication is raised while triggers come from the digital io port or the sync link.
// R07 - software picks one io port bit between 16 and 31 as the strobe input for the wait for strobe instruction.
// R08 - the strobe slope is off, rising or falling, and off never releases a waiting sequencer.
// R09 - the party driving the io port must make the configured transition on the chosen bit to release the wait.
// R10 - each playback core has a 512 ksample waveform cache from which waveforms are played.
// R11 - waveforms beyond the cache are fetched from a 64 or 500 msample main memory during playback.
// R12 - every trigger and strobe input is sampled into the sequencer clock and edges are found against the previous sample.
`ifndef WTIU_MAP_VH
`define WTIU_MAP_VH
`define WTIU_ADR_CTRL 8'h00
`define WTIU_ADR_LEVEL 8'h04
`define WTIU_ADR_STATUS 8'h08
`define WTIU_ADR_IRQ_ST 8'h0c
`define WTIU_ADR_IRQ_MASK 8'h10
`define WTIU_ADR_MEMCFG 8'h14
// ctrl fields
`define WTIU_CTRL_SLOPE_LSB 0
`define WTIU_CTRL_DSRC_LSB 2
`define WTIU_CTRL_SIDX_LSB 8
`define WTIU_CTRL_SSLOPE_LSB 12
`define WTIU_CTRL_RST 32'h0000_0001
// slope codes
`define WTIU_SLOPE_LEVEL 2'h0
`define WTIU_SLOPE_RISE 2'h1
`define WTIU_SLOPE_FALL 2'h2
`define WTIU_SLOPE_BOTH 2'h3
`define WTIU_SSLOPE_OFF 2'h0
`define WTIU_SSLOPE_RISE 2'h1
`define WTIU_SSLOPE_FALL 2'h2
// status and irq bits
`define WTIU_ST_MAIN 0
`define WTIU_ST_AUX 1
`define WTIU_ST_DIO 2
`define WTIU_ST_STROBE 3
// memory sizes in ksamples
`define WTIU_CACHE_KSA 32'd512
`define WTIU_MAIN_SMALL_KSA 32'd65536
`define WTIU_MAIN_LARGE_KSA 32'd512000
`endif

// *** core/wtiu_top.v ***
// Purpose: trigger, strobe conditioning and waveform fetch steering
// Assumes: all inputs synchronous to clk_i; synchronous active high reset
// Notes: edge detection adds one cycle of latency
//        a strobe edge with no wait pending is dropped, not stored for later
//        ce_i low freezes every flop, the bus included
//
// The implementer's own choices: the address map and the Wishbone register port.
`include "wtiu_map.vh"
module wtiu_top #(
    parameter ADC_W = 12,
    parameter NSRC = 8,
    parameter WADR_W = 30
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // trigger sources
    input wire [ADC_W-1:0] ana_trig_i,
    input wire aux_trig_i,
    input wire [NSRC-1:0] dig_src_i,
    input wire [31:0] digital_io_port_i,
    input wire sync_link_trig_i,
    // sequencer side
    input wire wait_for_strobe_instruction_i,
    input wire [WADR_W-1:0] wave_adr_i,
    output reg main_trig_o,
    output reg dig_trig_o,
    output reg strobe_release_o,
    output reg from_main_mem_o,
    output wire irq_o
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [31:0] ctrl_q;
reg [ADC_W-1:0] level_q;
reg [3:0] irq_st_q;
reg [3:0] irq_mask_q;
reg main_big_q;
reg st_main_q;
reg st_aux_q;
reg st_dio_q;
reg ana_q;
reg ana_p_q;
reg aux_q;
reg aux_p_q;
reg dsrc_q;
reg dsrc_p_q;
reg stb_q;
reg stb_p_q;
reg sync_q;
reg sync_p_q;
reg [1:0] sw_q;
reg [1:0] sw_d;
reg [31:0] rd_d;

// strobe wait machine, one-hot
localparam [1:0] SW_IDLE = 2'b01;
localparam [1:0] SW_WAIT = 2'b10;

wire [1:0] slope = ctrl_q[`WTIU_CTRL_SLOPE_LSB +: 2];
wire [2:0] dsrc_sel = ctrl_q[`WTIU_CTRL_DSRC_LSB +: 3];
wire [3:0] sidx = ctrl_q[`WTIU_CTRL_SIDX_LSB +: 4];
wire [1:0] sslope = ctrl_q[`WTIU_CTRL_SSLOPE_LSB +: 2];
wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
wire rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
wire waiting = (sw_q == SW_WAIT);

////////////////////////////////////////////////////////////////////////////////
// input sampling and edge detection
wire ana_cmp = (ana_trig_i >= level_q); // see R02
wire dsrc_bit = dig_src_i[dsrc_sel]; // see R05
wire stb_bit = digital_io_port_i[{1'b1, sidx}]; // see R07
always @(posedge clk_i) begin
    if (rst_i) begin
        // level_q resets to zero, so the compare idles high; starting low would fake a rising edge
        ana_q <= 1'b1;
        ana_p_q <= 1'b1;
        {aux_q, aux_p_q, dsrc_q, dsrc_p_q} <= 4'h0;
        {stb_q, stb_p_q, sync_q, sync_p_q} <= 4'h0;
    end else if (ce_i) begin
        ana_q <= ana_cmp; // see R12
        ana_p_q <= ana_q;
        aux_q <= aux_trig_i;
        aux_p_q <= aux_q;
        dsrc_q <= dsrc_bit;
        dsrc_p_q <= dsrc_q;
        stb_q <= stb_bit;
        stb_p_q <= stb_q;
        sync_q <= sync_link_trig_i;
        sync_p_q <= sync_q;
    end
end

// edges are judged against the previous sample, so a change needs one settled sample on each side
wire ana_rise = ana_q & ~ana_p_q; // see R12
wire ana_fall = ~ana_q & ana_p_q;
reg main_ev;
always @* begin
    case (slope) // see R01
        `WTIU_SLOPE_LEVEL: main_ev = ana_q;
        `WTIU_SLOPE_RISE: main_ev = ana_rise;
        `WTIU_SLOPE_FALL: main_ev = ana_fall;
        default: main_ev = ana_rise | ana_fall;
    endcase
end
wire aux_ev = aux_q & ~aux_p_q;
wire dsrc_ev = dsrc_q & ~dsrc_p_q;
wire sync_ev = sync_q & ~sync_p_q;
wire dio_ev = dsrc_ev | sync_ev;
reg stb_ev;
always @* begin
    case (sslope) // see R08
        `WTIU_SSLOPE_RISE: stb_ev = stb_q & ~stb_p_q;
        `WTIU_SSLOPE_FALL: stb_ev = ~stb_q & stb_p_q;
        default: stb_ev = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// sequencer outputs
// the waiting state is held here so a strobe edge before the instruction is ignored
wire release_now = waiting & stb_ev; // see R08
// in the wait state the releasing edge wins over a repeated wait instruction
always @* begin
    sw_d = sw_q;
    case (sw_q)
        SW_IDLE: begin
            if (wait_for_strobe_instruction_i)
                sw_d = SW_WAIT;
        end
        SW_WAIT: begin
            if (stb_ev)
                sw_d = SW_IDLE; // see R08
        end
        default: sw_d = SW_IDLE;
    endcase
end

// an illegal state code falls back to idle through the default branch above
always @(posedge clk_i) begin
    if (rst_i) begin
        main_trig_o <= 1'b0;
        dig_trig_o <= 1'b0;
        strobe_release_o <= 1'b0;
        sw_q <= SW_IDLE;
    end else if (ce_i) begin
        main_trig_o <= main_ev; // see R01
        dig_trig_o <= dio_ev; // see R05
        strobe_release_o <= release_now; // see R08
        sw_q <= sw_d;
    end
end

// cache holds the low addresses; anything beyond is served from main memory
// the product is formed at 32 bits and cut to the address width on purpose
localparam [31:0] CACHE_SA = `WTIU_CACHE_KSA * 32'd1024;
always @(posedge clk_i) begin
    if (rst_i)
        from_main_mem_o <= 1'b0;
    else if (ce_i)
        from_main_mem_o <= (wave_adr_i >= CACHE_SA[WADR_W-1:0]); // see R10 see R11
end
wire [31:0] main_ksa = main_big_q ? `WTIU_MAIN_LARGE_KSA : `WTIU_MAIN_SMALL_KSA; // see R11

////////////////////////////////////////////////////////////////////////////////
// status flags and interrupts; set wins over clear
wire [3:0] ev_vec = {release_now, dio_ev, aux_ev, main_ev};
wire [3:0] w1c = (wr && wb_adr_i == `WTIU_ADR_IRQ_ST && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
wire st_clr = wr && wb_adr_i == `WTIU_ADR_STATUS && wb_sel_i[0];
wire [3:0] irq_st_d;

genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
        // set wins: an event in the cycle of its write-one-to-clear keeps the bit
        assign irq_st_d[gi] = ev_vec[gi] | (irq_st_q[gi] & ~w1c[gi]);
    end
endgenerate

always @(posedge clk_i) begin
    if (rst_i) begin
        irq_st_q <= 4'h0;
    end else if (ce_i) begin
        irq_st_q <= irq_st_d;
    end
end

// level mode sets the main flag on every cycle the level is high
always @(posedge clk_i) begin
    if (rst_i) begin
        st_main_q <= 1'b0;
    end else if (ce_i) begin
        if (main_ev)
            st_main_q <= 1'b1; // see R03
        else if (st_clr && wb_dat_i[`WTIU_ST_MAIN])
            st_main_q <= 1'b0;
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        st_aux_q <= 1'b0;
    end else if (ce_i) begin
        if (aux_ev)
            st_aux_q <= 1'b1; // see R04
        else if (st_clr && wb_dat_i[`WTIU_ST_AUX])
            st_aux_q <= 1'b0;
    end
end

// the dio flag stretches over the event and the trigger pulse it causes
always @(posedge clk_i) begin
    if (rst_i) begin
        st_dio_q <= 1'b0;
    end else if (ce_i) begin
        st_dio_q <= dio_ev | dig_trig_o; // see R06
    end
end
assign irq_o = |(irq_st_q & irq_mask_q);

////////////////////////////////////////////////////////////////////////////////
// wishbone slave, one wait-free ack a cycle after the strobe
wire wr_ctrl = wr && (wb_adr_i == `WTIU_ADR_CTRL);
wire wr_level = wr && (wb_adr_i == `WTIU_ADR_LEVEL);
wire wr_mask = wr && (wb_adr_i == `WTIU_ADR_IRQ_MASK) && wb_sel_i[0];
wire wr_memcfg = wr && (wb_adr_i == `WTIU_ADR_MEMCFG) && wb_sel_i[0];

// ack is a single pulse: the ~wb_ack_o term stops a held strobe from being taken twice
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
    end else if (ce_i) begin
        wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
end

// ctrl takes the two low byte lanes; the upper half is reserved and keeps its reset value
always @(posedge clk_i) begin
    if (rst_i) begin
        ctrl_q <= `WTIU_CTRL_RST;
    end else if (ce_i && wr_ctrl) begin
        if (wb_sel_i[0])
            ctrl_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
            ctrl_q[15:8] <= wb_dat_i[15:8];
    end
end

// the threshold ignores byte lanes so one write always moves the whole compare value
always @(posedge clk_i) begin
    if (rst_i) begin
        level_q <= {ADC_W{1'b0}};
    end else if (ce_i && wr_level) begin
        level_q <= wb_dat_i[ADC_W-1:0]; // see R02
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        irq_mask_q <= 4'h0;
    end else if (ce_i && wr_mask) begin
        irq_mask_q <= wb_dat_i[3:0];
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        main_big_q <= 1'b0;
    end else if (ce_i && wr_memcfg) begin
        main_big_q <= wb_dat_i[0]; // see R11
    end
end

// read data is held from one read to the next
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_dat_o <= 32'h0000_0000;
    end else if (ce_i && rd) begin
        wb_dat_o <= rd_d;
    end
end

// read mux; unmapped addresses read as zero but are still acknowledged
always @* begin
    case (wb_adr_i)
        `WTIU_ADR_CTRL: rd_d = {16'h0000, 2'b00, sslope, sidx, 3'h0, dsrc_sel, slope};
        `WTIU_ADR_LEVEL: rd_d = {{(32-ADC_W){1'b0}}, level_q};
        `WTIU_ADR_STATUS: rd_d = {28'h000_0000, waiting, st_dio_q, st_aux_q, st_main_q};
        `WTIU_ADR_IRQ_ST: rd_d = {28'h000_0000, irq_st_q};
        `WTIU_ADR_IRQ_MASK: rd_d = {28'h000_0000, irq_mask_q};
        `WTIU_ADR_MEMCFG: rd_d = {main_ksa[30:0], main_big_q};
        default: rd_d = 32'h0000_0000;
    endcase
end

endmodule // wtiu_top

// *** tb/wtiu_src.sv ***
// Purpose: io port model for the strobe bit
// Assumes: one go pulse per wanted transition
// Notes: port bits never selected stay low; a bit once selected keeps its last level
module wtiu_src (
    // control
    input wire clk_i,
    input wire go_i,
    input wire fall_i,
    input wire [3:0] idx_i,
    // io port
    output reg [31:0] dio_o
);
    timeunit 1ns;
    timeprecision 1ns;
    reg ph_q = 1'b0;
    initial dio_o = 32'h0000_0000;
    ////////////////////////////////
    // the opposite level first, so the wanted edge is always a real one
    always @(posedge clk_i) begin
        ph_q <= go_i;
        if (go_i) dio_o[5'd16 + idx_i] <= fall_i;
        else if (ph_q) dio_o[5'd16 + idx_i] <= !fall_i;
    end
endmodule // wtiu_src

// *** tb/wtiu_sva.sv ***
// Purpose: port checker for the trigger unit
// Assumes: full word writes, ce_i high
// Notes: ctrl and level mirrored from bus writes
module wtiu_sva #(
    parameter ADC_W = 12,
    parameter NSRC = 8,
    parameter WADR_W = 30
) (
    // clock, reset, bus
    input wire clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    // sources and outputs
    input wire [ADC_W-1:0] ana_trig_i,
    input wire [NSRC-1:0] dig_src_i,
    input wire [31:0] digital_io_port_i,
    input wire [WADR_W-1:0] wave_adr_i,
    input wire sync_link_trig_i, main_trig_o, dig_trig_o, strobe_release_o, from_main_mem_o
);
    reg [31:0] ctl_q;
    reg [ADC_W-1:0] lvl_q;
    reg [2:0] ok_q;
    reg [1:0] c_q, d_q, y_q, s_q;
    wire tk = wb_cyc_i & wb_stb_i & ce_i & ~wb_ack_o;
    wire [1:0] sl = ctl_q[1:0];
    wire [1:0] ss = ctl_q[13:12];
    wire em = sl == 2'h0 ? c_q[0] : sl == 2'h1 ? c_q[0] & ~c_q[1] : sl == 2'h2 ? c_q[1] & ~c_q[0] : ^c_q;
    wire ed = d_q[0] & ~d_q[1] | y_q[0] & ~y_q[1];
    wire es = ss == 2'h1 ? s_q[0] & ~s_q[1] : ss == 2'h2 && s_q[1] & ~s_q[0];
    wire off = ss == 2'h0 || ss == 2'h3;
    ////////////////////////////////
    // ok_q hides the cycles whose history still reaches into reset
    always @(posedge clk_i) begin
        c_q <= {c_q[0], ana_trig_i >= lvl_q};
        d_q <= {d_q[0], dig_src_i[ctl_q[4:2]]};
        y_q <= {y_q[0], sync_link_trig_i};
        s_q <= {s_q[0], digital_io_port_i[5'd16 + ctl_q[11:8]]};
        ok_q <= rst_i ? 3'h0 : {ok_q[1:0], 1'b1};
        if (rst_i) ctl_q <= 32'h0000_0001;
        else if (tk && wb_we_i && wb_adr_i == 8'h00) ctl_q <= wb_dat_i;
        if (rst_i) lvl_q <= '0;
        else if (tk && wb_we_i && wb_adr_i == 8'h04) lvl_q <= wb_dat_i[ADC_W-1:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; tk |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("long ack");
    property p_main; &ok_q |-> main_trig_o == $past(em); endproperty
    a_main: assert property (p_main) else $error("main trigger");
    property p_mem; &ok_q |-> from_main_mem_o == ($past(wave_adr_i) >= 524288); endproperty
    a_mem: assert property (p_mem) else $error("memory select");
    property p_dig; &ok_q |-> dig_trig_o == $past(ed); endproperty
    a_dig: assert property (p_dig) else $error("digital trigger");
    property p_soff; $past(off) |-> !strobe_release_o; endproperty
    a_soff: assert property (p_soff) else $error("release while off");
    property p_srel; strobe_release_o |-> $past(es); endproperty
    a_srel: assert property (p_srel) else $error("release without edge");
    property p_rel1; strobe_release_o |=> !strobe_release_o; endproperty
    a_rel1: assert property (p_rel1) else $error("long release");
    c_main: cover property (main_trig_o);
    c_dig: cover property (dig_trig_o);
    c_rel: cover property (strobe_release_o);
endmodule // wtiu_sva
bind wtiu_top wtiu_sva #(.ADC_W(ADC_W), .NSRC(NSRC), .WADR_W(WADR_W)) i_wtiu_sva (.clk_i, .rst_i, .ce_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_dat_i, .ana_trig_i, .dig_src_i, .digital_io_port_i,
    .wave_adr_i, .sync_link_trig_i, .main_trig_o, .dig_trig_o, .strobe_release_o, .from_main_mem_o);

// *** tb/wtiu_top_test.sv ***
// Purpose: self-checking bench for the trigger unit
// Assumes: ce_i and wb_sel_i tied, full word access
// Notes: output pulses counted per cycle
module wtiu_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, aux = 0, sync = 0, wt = 0, go = 0;
    logic [7:0] adr = 8'h00, src = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] got = 32'h0000_0000;
    logic [11:0] ana = 12'h000;
    logic [29:0] wa = 30'h0000_0000;
    logic [3:0] ix = 4'h0;
    logic [1:0] ss = 2'h0;
    wire [31:0] rdat, digital_io_port;
    wire ack, mt, dt, sr, fm, irq;
    int miscompares = 0, n_tests = 0, n_cyc = 0, n_m = 0, n_d = 0, n_r = 0, b;
    wtiu_top i_wtiu_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .ana_trig_i(ana),
        .aux_trig_i(aux), .dig_src_i(src), .digital_io_port_i(digital_io_port), .sync_link_trig_i(sync),
        .wait_for_strobe_instruction_i(wt), .wave_adr_i(wa), .main_trig_o(mt), .dig_trig_o(dt),
        .strobe_release_o(sr), .from_main_mem_o(fm), .irq_o(irq));
    wtiu_src i_wtiu_src (.clk_i(clk_i), .go_i(go), .fall_i(ss == 2'h2), .idx_i(ix), .dio_o(digital_io_port));
    ////////////////////////////////
    initial forever #25 clk_i = ~clk_i;
    // the timeout guards every unbounded wait on ack
    always @(posedge clk_i) begin
        n_cyc++;
        n_m += mt;
        n_d += dt;
        n_r += sr;
        if (n_cyc == 5000) begin
            miscompares++;
            summarize();
        end
    end
    task t(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task chk(string n, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task bus(logic w, logic [7:0] a, logic [31:0] d);
        cyc <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        got = rdat;
        cyc <= 0;
        @(posedge clk_i);
    endtask
    task t_slope;
        bus(1, 8'h04, 32'h0000_0064);
        for (int s = 0; s < 4; s++) begin
            bus(1, 8'h00, s);
            b = n_m;
            ana <= 12'h0c8;
            t(3);
            ana <= 12'h000;
            t(5);
            chk("main", s == 0 ? 3 : s == 3 ? 2 : 1, n_m - b);
        end
        bus(0, 8'h08, 0);
        chk("main flag", 1, 32'(got[0]));
    endtask
    task t_flags;
        aux <= 1;
        t(3);
        aux <= 0;
        t(3);
        bus(0, 8'h08, 0);
        chk("aux flag", 1, 32'(got[1]));
        bus(1, 8'h08, 32'h0000_0002);
        bus(0, 8'h08, 0);
        chk("aux clear", 0, 32'(got[1]));
        chk("irq masked", 0, 32'(irq));
        bus(1, 8'h10, 32'h0000_0001);
        chk("irq", 1, 32'(irq));
        bus(1, 8'h0c, 32'h0000_000f);
        chk("irq clear", 0, 32'(irq));
    endtask
    task t_dig;
        bus(1, 8'h00, 32'h0000_0015);
        b = n_d;
        src <= 8'h04;
        t(3);
        src <= 8'h20;
        t(3);
        src <= 8'h00;
        sync <= 1;
        t(3);
        sync <= 0;
        t(3);
        chk("dig", 2, n_d - b);
        bus(0, 8'h0c, 0);
        chk("dio irq", 1, 32'(got[2]));
    endtask
    task t_strobe(logic [3:0] i, logic [1:0] s);
        bus(1, 8'h00, {18'h0, s, i, 8'h01});
        b = n_r;
        ix <= i;
        ss <= s;
        wt <= 1;
        t(1);
        wt <= 0;
        go <= 1;
        t(1);
        go <= 0;
        t(6);
        chk("strobe", s == 2'h1 || s == 2'h2, n_r - b);
        bus(0, 8'h00, 0);
        chk("ctrl", {18'h0, s, i, 8'h01}, got);
    endtask
    task t_mem;
        wa <= 30'h0007_ffff;
        t(2);
        chk("mem low", 0, 32'(fm));
        wa <= 30'h0008_0000;
        t(2);
        chk("mem high", 1, 32'(fm));
        bus(0, 8'h14, 0);
        chk("mem small", {31'h0001_0000, 1'b0}, got);
        bus(1, 8'h14, 32'h0000_0001);
        bus(0, 8'h14, 0);
        chk("mem large", {31'h0007_d000, 1'b1}, got);
    endtask
    task summarize;
        if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        t(4);
        rst_i <= 0;
        t(1);
        bus(0, 8'h00, 0);
        chk("ctrl reset", 1, got);
        bus(0, 8'h40, 0);
        chk("unmapped", 0, got);
        t_slope();
        t_flags();
        t_dig();
        t_strobe(4'hf, 2'h1);
        t_strobe(4'h0, 2'h2);
        t_strobe(4'h7, 2'h0);
        t_strobe(4'h3, 2'h3);
        t_mem();
        summarize();
    end
endmodule // wtiu_top_test
